/* design/pll_holdover_config_fields.sv */
// Summary of operation
// - six-bit upper and lower tuning DAC trip fields are stored for readback only
// - rail detect enable makes a trip point unlock the first loop
// - manual DAC value defaults 512; reads return the live DAC value
// - manual enable bit selects manual DAC override, else automatic
// - holdover exits after lock holds for the exit count, default 512
// - DAC update clock is first detector rate over divisor, default 4
// - first loop lock indicator asserts after lock count, default 1024
// - second loop lock asserts after window count, default 8192
// - two-bit first loop lock window, default code 3
// - first loop ref and feedback dividers 14-bit, defaults 96 and 192
// - second loop ref divider 12-bit, default 4
// - second loop feedback divider 18-bit, default 48
// - prescaler 3-bit, 2 to 8, default 2
// - three two-bit input pre-dividers, code 0 divides by one
// - doubler bit doubles second loop reference, default off
// - fast detector bit allows rates above 100 MHz, default set
// - five-bit readback address selects register, default 31
// - readback happens at programmed latch level, default low
// - write lock refuses writes to registers 0 through 30
`timescale 1ns/100ps
`default_nettype none
`include "holdover_cfg_defs.svh"
module pll_holdover_config_fields #(
  parameter int DAC_WIDTH = 10
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // serial port
  input wire holdover_cfg_pkg::serial_in_t serial_i,
  output logic serial_data_o,
  // loop status
  input wire holdover_cfg_pkg::loop_status_t status_i,
  input wire logic [DAC_WIDTH-1:0] auto_dac_i,
  // configuration and status out
  output holdover_cfg_pkg::divider_cfg_t div_cfg_o,
  output logic [DAC_WIDTH-1:0] dac_value_o,
  output logic dac_update_o,
  output logic holdover_o,
  output logic first_loop_unlocked_o,
  output logic lock_indicator_o,
  output logic second_loop_locked_o
);
  import holdover_cfg_pkg::*;

  localparam int NREG = 11;
  localparam logic [4:0] ADDRS [NREG] = '{`ADDR_DAC_TRIP, `ADDR_DAC_MAN, `ADDR_XTAL,
    `ADDR_LF, `ADDR_DAC_CLK, `ADDR_L2_LOCK, `ADDR_L1_REF, `ADDR_REF_FB, `ADDR_FB_CAL,
    `ADDR_PRESC, `ADDR_READBACK};
  localparam logic [31:0] MASKS [NREG] = '{`MASK_DAC_TRIP, `MASK_DAC_MAN, `MASK_XTAL,
    `MASK_LF, `MASK_DAC_CLK, `MASK_L2_LOCK, `MASK_L1_REF, `MASK_REF_FB, `MASK_FB_CAL,
    `MASK_PRESC, `MASK_READBACK};
  localparam logic [31:0] RSTS [NREG] = '{`RST_DAC_TRIP, `RST_DAC_MAN, `RST_XTAL,
    `RST_LF, `RST_DAC_CLK, `RST_L2_LOCK, `RST_L1_REF, `RST_REF_FB, `RST_FB_CAL,
    `RST_PRESC, `RST_READBACK};
  localparam int I_TRIP = 0;
  localparam int I_MAN = 1;
  localparam int I_XTAL = 2;
  localparam int I_LF = 3;
  localparam int I_DCLK = 4;
  localparam int I_L2 = 5;
  localparam int I_L1R = 6;
  localparam int I_RF = 7;
  localparam int I_CAL = 8;
  localparam int I_PRE = 9;
  localparam int I_RB = 10;

  // serial port sampling: edges detected on the synchronous pin samples
  logic sclk_reg;
  logic latch_reg;
  logic [31:0] shift_reg;
  logic [31:0] regs_reg [NREG];
  logic [31:0] rb_shift_reg;
  logic serial_data_reg;

  wire sclk_rise = serial_i.clk & ~sclk_reg;
  wire sclk_fall = ~serial_i.clk & sclk_reg;
  wire latch_rise = serial_i.latch & ~latch_reg;
  wire [4:0] wr_addr = shift_reg[4:0];
  wire write_locked = regs_reg[I_RB][`B_WLOCK];
  wire rb_level = regs_reg[I_RB][`B_RB_LEVEL];
  wire [4:0] rb_addr = regs_reg[I_RB][`F_RB_ADDR];
  // readback shifts while latch sits at the programmed level
  wire rb_active = (serial_i.latch == rb_level);

  // readback word selection, unmapped addresses read as zero
  logic [31:0] rb_word;
  always_comb
  begin
    rb_word = 32'h0000_0000;
    if (rb_addr == `ADDR_DAC_TRIP)
    begin
      rb_word = regs_reg[I_TRIP] & `MASK_DAC_TRIP;
    end
    else if (rb_addr == `ADDR_DAC_MAN)
    begin
      rb_word = regs_reg[I_MAN] & `MASK_DAC_MAN;
      rb_word[`F_MANUAL_DAC_VALUE] = 10'(dac_value_o);
    end
    else if (rb_addr == `ADDR_XTAL)
    begin
      rb_word = regs_reg[I_XTAL] & `MASK_XTAL;
    end
    else if (rb_addr == `ADDR_LF)
    begin
      rb_word = regs_reg[I_LF] & `MASK_LF;
    end
    else if (rb_addr == `ADDR_DAC_CLK)
    begin
      rb_word = regs_reg[I_DCLK] & `MASK_DAC_CLK;
    end
    else if (rb_addr == `ADDR_L2_LOCK)
    begin
      rb_word = regs_reg[I_L2] & `MASK_L2_LOCK;
    end
    else if (rb_addr == `ADDR_L1_REF)
    begin
      rb_word = regs_reg[I_L1R] & `MASK_L1_REF;
    end
    else if (rb_addr == `ADDR_REF_FB)
    begin
      rb_word = regs_reg[I_RF] & `MASK_REF_FB;
    end
    else if (rb_addr == `ADDR_FB_CAL)
    begin
      rb_word = regs_reg[I_CAL] & `MASK_FB_CAL;
    end
    else if (rb_addr == `ADDR_PRESC)
    begin
      rb_word = regs_reg[I_PRE] & `MASK_PRESC;
    end
    else if (rb_addr == `ADDR_READBACK)
    begin
      rb_word = regs_reg[I_RB] & `MASK_READBACK;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sclk_reg <= 1'b0;
      latch_reg <= 1'b0;
      shift_reg <= 32'h0000_0000;
    end
    else
    begin
      sclk_reg <= serial_i.clk;
      latch_reg <= serial_i.latch;
      if (sclk_rise)
      begin
        shift_reg <= {shift_reg[30:0], serial_i.data};
      end
    end
  end

  // register bank, one entry per mapped address
  for (genvar g = 0; g < NREG; g++)
  begin : g_reg
    wire hit = latch_rise && (wr_addr == ADDRS[g]);
    wire allowed = !write_locked || (ADDRS[g] == `ADDR_READBACK);
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        regs_reg[g] <= RSTS[g];
      end
      else if (hit && allowed)
      begin
        regs_reg[g] <= shift_reg & MASKS[g];
      end
    end
  end

  // readback shifter: reloads every cycle while latch is off the readback level, shifts msb first
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rb_shift_reg <= 32'h0000_0000;
      serial_data_reg <= 1'b0;
    end
    else
    begin
      if (!rb_active)
      begin
        rb_shift_reg <= rb_word;
      end
      else if (sclk_fall)
      begin
        rb_shift_reg <= {rb_shift_reg[30:0], 1'b0};
      end
      serial_data_reg <= rb_active & rb_shift_reg[31];
    end
  end
  assign serial_data_o = serial_data_reg;

  // divider and loop configuration outputs, fields picked from the bank
  divider_cfg_t div_cfg_next;
  assign div_cfg_next.input_pre_divs = {regs_reg[I_L1R][`F_PRE2], regs_reg[I_L1R][`F_PRE1],
    regs_reg[I_L1R][`F_PRE0]};
  assign div_cfg_next.first_loop_ref_divider = regs_reg[I_L1R][`F_CNT14];
  assign div_cfg_next.first_loop_fb_divider = regs_reg[I_RF][`F_CNT14];
  assign div_cfg_next.second_loop_ref_divider = regs_reg[I_RF][`F_L2_R];
  assign div_cfg_next.second_loop_fb_divider = regs_reg[I_PRE][`F_L2_N];
  assign div_cfg_next.second_loop_prescaler = regs_reg[I_PRE][`F_PRESC];
  assign div_cfg_next.reference_doubler_enable = regs_reg[I_L2][`B_DOUBLER];
  assign div_cfg_next.fast_detector_allow = regs_reg[I_CAL][`B_FAST_PD];
  assign div_cfg_next.first_loop_lock_window = regs_reg[I_LF][`F_L1_WIN];
  assign div_cfg_next.second_loop_lock_window = regs_reg[I_L2][`F_L2_WIN];
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      div_cfg_o <= '0;
    end
    else
    begin
      div_cfg_o <= div_cfg_next;
    end
  end

  // tuning DAC: manual override or automatic, updated on divided ticks
  logic [9:0] dac_div_cnt_reg;
  logic dac_update_reg;
  logic [DAC_WIDTH-1:0] dac_reg;
  wire [9:0] dac_div = regs_reg[I_DCLK][`F_DAC_DIV];
  wire dac_tick = status_i.first_pd_tick && (dac_div_cnt_reg + 10'h001 >= dac_div);
  wire [DAC_WIDTH-1:0] dac_src = regs_reg[I_MAN][`B_MAN_EN] ?
    DAC_WIDTH'(regs_reg[I_MAN][`F_MANUAL_DAC_VALUE]) : auto_dac_i;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dac_div_cnt_reg <= 10'h000;
      dac_update_reg <= 1'b0;
      dac_reg <= DAC_WIDTH'(10'h200);
    end
    else
    begin
      dac_update_reg <= dac_tick;
      if (status_i.first_pd_tick)
      begin
        dac_div_cnt_reg <= dac_tick ? 10'h000 : dac_div_cnt_reg + 10'h001;
      end
      if (dac_tick)
      begin
        dac_reg <= dac_src;
      end
    end
  end
  assign dac_value_o = dac_reg;
  assign dac_update_o = dac_update_reg;

  // rail trip: analog comparators report rails; trip codes go out in regs
  wire rail_trip = regs_reg[I_TRIP][`B_RAIL_EN] &&
    (status_i.dac_at_high_rail || status_i.dac_at_low_rail);
  wire l1_ok = status_i.first_loop_locked && !rail_trip;

  // lock qualification counters
  logic [13:0] l1_cnt_reg;
  logic [13:0] l2_cnt_reg;
  logic [13:0] hold_cnt_reg;
  logic lock_reg;
  logic l2_lock_reg;
  hold_state_t hold_state_reg;
  wire [13:0] l1_target = regs_reg[I_DCLK][`F_CNT14];
  wire [13:0] l2_target = regs_reg[I_L2][`F_CNT14];
  wire [13:0] hold_target = regs_reg[I_MAN][`F_CNT14];
  wire force_hold = regs_reg[I_MAN][`B_FORCE_HOLD];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      l1_cnt_reg <= 14'h0000;
      lock_reg <= 1'b0;
    end
    else if (!l1_ok)
    begin
      l1_cnt_reg <= 14'h0000;
      lock_reg <= 1'b0;
    end
    else if (status_i.first_pd_tick && !lock_reg)
    begin
      l1_cnt_reg <= l1_cnt_reg + 14'h0001;
      lock_reg <= (l1_cnt_reg + 14'h0001 >= l1_target);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      l2_cnt_reg <= 14'h0000;
      l2_lock_reg <= 1'b0;
    end
    else if (!status_i.second_loop_in_window)
    begin
      l2_cnt_reg <= 14'h0000;
      l2_lock_reg <= 1'b0;
    end
    else if (status_i.second_pd_tick && !l2_lock_reg)
    begin
      l2_cnt_reg <= l2_cnt_reg + 14'h0001;
      l2_lock_reg <= (l2_cnt_reg + 14'h0001 >= l2_target);
    end
  end

  // holdover: entered on loss of lock or force, left after exit count
  hold_state_t hold_state_next;
  logic [13:0] hold_cnt_next;
  wire hold_enter = force_hold || (lock_reg && !l1_ok);
  wire hold_clear = !force_hold && l1_ok;
  wire [13:0] hold_cnt_inc = hold_cnt_reg + 14'h0001;
  wire hold_done = (hold_cnt_inc >= hold_target);
  always_comb
  begin
    hold_state_next = hold_state_reg;
    hold_cnt_next = hold_cnt_reg;
    case (hold_state_reg)
      HOLD_OFF:
      begin
        hold_cnt_next = 14'h0000;
        if (hold_enter)
        begin
          hold_state_next = HOLD_ACTIVE;
        end
      end
      HOLD_ACTIVE:
      begin
        hold_cnt_next = 14'h0000;
        if (hold_clear)
        begin
          hold_state_next = HOLD_EXITING;
        end
      end
      HOLD_EXITING:
      begin
        if (!hold_clear)
        begin
          hold_state_next = HOLD_ACTIVE;
        end
        else if (status_i.first_pd_tick)
        begin
          hold_cnt_next = hold_cnt_inc;
          if (hold_done)
          begin
            hold_state_next = HOLD_OFF;
          end
        end
      end
      default:
      begin
        hold_state_next = HOLD_OFF;
        hold_cnt_next = 14'h0000;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      hold_state_reg <= HOLD_OFF;
      hold_cnt_reg <= 14'h0000;
    end
    else
    begin
      hold_state_reg <= hold_state_next;
      hold_cnt_reg <= hold_cnt_next;
    end
  end

  assign holdover_o = (hold_state_reg != HOLD_OFF);
  assign first_loop_unlocked_o = !l1_ok;
  assign lock_indicator_o = lock_reg;
  assign second_loop_locked_o = l2_lock_reg;
endmodule // pll_holdover_config_fields
`default_nettype wire

/* common/holdover_cfg_defs.svh */
`ifndef HOLDOVER_CFG_DEFS_SVH
`define HOLDOVER_CFG_DEFS_SVH
// register addresses (5-bit address in the low bits of each serial word)
`define ADDR_DAC_TRIP 5'h0e
`define ADDR_DAC_MAN 5'h0f
`define ADDR_XTAL 5'h10
`define ADDR_LF 5'h18
`define ADDR_DAC_CLK 5'h19
`define ADDR_L2_LOCK 5'h1a
`define ADDR_L1_REF 5'h1b
`define ADDR_REF_FB 5'h1c
`define ADDR_FB_CAL 5'h1d
`define ADDR_PRESC 5'h1e
`define ADDR_READBACK 5'h1f
// masks of writable field bits per register
`define MASK_DAC_TRIP 32'h000fcfe0
`define MASK_DAC_MAN 32'hffdfffe0
`define MASK_XTAL 32'hc0000000
`define MASK_LF 32'hff7777c0
`define MASK_DAC_CLK 32'hffcfffc0
`define MASK_L2_LOCK 32'hfc0fffe0
`define MASK_L1_REF 32'h1fffffe0
`define MASK_REF_FB 32'hffffffc0
`define MASK_FB_CAL 32'h07ffffe0
`define MASK_PRESC 32'h077fffe0
`define MASK_READBACK 32'h003f0020
// power-on defaults (field bits only)
`define RST_DAC_TRIP 32'h00000000
`define RST_DAC_MAN 32'h80008000
`define RST_XTAL 32'h00000000
`define RST_LF 32'h000000c0
`define RST_DAC_CLK 32'h01010000
`define RST_L2_LOCK 32'h0c080000
`define RST_L1_REF 32'h10001800
`define RST_REF_FB 32'h00403000
`define RST_FB_CAL 32'h07800600
`define RST_PRESC 32'h02000600
`define RST_READBACK 32'h001f0000
// field positions
`define F_HI_TRIP 19:14
`define F_LO_TRIP 11:6
`define B_RAIL_EN 5
`define F_MANUAL_DAC_VALUE 31:22
`define B_MAN_EN 20
`define F_CNT14 19:6
`define B_FORCE_HOLD 5
`define F_DAC_DIV 31:22
`define F_L1_WIN 7:6
`define F_L2_WIN 31:30
`define B_DOUBLER 29
`define F_PRE2 25:24
`define F_PRE1 23:22
`define F_PRE0 21:20
`define F_L2_R 31:20
`define B_FAST_PD 23
`define F_L2_N 22:5
`define F_PRESC 26:24
`define B_RB_LEVEL 21
`define F_RB_ADDR 20:16
`define B_WLOCK 5
`endif

/* common/holdover_cfg_pkg.sv */
package holdover_cfg_pkg;
  // serial port pins
  typedef struct packed {
    logic clk;
    logic data;
    logic latch;
  } serial_in_t;
  // loop status from the analog side
  typedef struct packed {
    logic first_loop_locked;
    logic second_loop_in_window;
    logic dac_at_high_rail;
    logic dac_at_low_rail;
    logic first_pd_tick;
    logic second_pd_tick;
  } loop_status_t;
  typedef struct packed {
    logic [5:0] input_pre_divs;
    logic [13:0] first_loop_ref_divider;
    logic [13:0] first_loop_fb_divider;
    logic [11:0] second_loop_ref_divider;
    logic [17:0] second_loop_fb_divider;
    logic [2:0] second_loop_prescaler;
    logic reference_doubler_enable;
    logic fast_detector_allow;
    logic [1:0] first_loop_lock_window;
    logic [1:0] second_loop_lock_window;
  } divider_cfg_t;
  typedef enum logic [1:0] {
    HOLD_OFF = 2'b00,
    HOLD_ACTIVE = 2'b01,
    HOLD_EXITING = 2'b10
  } hold_state_t;
endpackage

/* bench/pll_holdover_config_fields_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module pll_holdover_config_fields_chk #(
  parameter int DAC_WIDTH = 10
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // watched ports
  input wire holdover_cfg_pkg::serial_in_t serial_i,
  input wire logic serial_data_o,
  input wire holdover_cfg_pkg::loop_status_t status_i,
  input wire logic [DAC_WIDTH-1:0] auto_dac_i,
  input wire holdover_cfg_pkg::divider_cfg_t div_cfg_o,
  input wire logic [DAC_WIDTH-1:0] dac_value_o,
  input wire logic dac_update_o,
  input wire logic holdover_o,
  input wire logic first_loop_unlocked_o,
  input wire logic lock_indicator_o,
  input wire logic second_loop_locked_o
);
  import holdover_cfg_pkg::*;
  logic latch_q;
  logic [2:0] since_latch;
  // cycles since the last latch rise, saturating
  always_ff @(posedge clk_i)
  begin
    latch_q <= serial_i.latch;
    if (rst_i || (serial_i.latch && !latch_q))
      since_latch <= 3'h0;
    else if (since_latch != 3'h7)
      since_latch <= since_latch + 3'h1;
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence lock_lost;
    status_i.first_loop_locked ##1 !status_i.first_loop_locked;
  endsequence
  a_reset_loads:
    assert property ($fell(rst_i) |-> dac_value_o == DAC_WIDTH'(10'h200) && !lock_indicator_o)
    else $error("dac or lock not at power-on value");
  a_unlock_on_loss:
    assert property (!status_i.first_loop_locked |-> first_loop_unlocked_o)
    else $error("unlock flag low while lock lost");
  a_locked_no_trip:
    assert property (status_i.first_loop_locked && !status_i.dac_at_high_rail
      && !status_i.dac_at_low_rail |-> !first_loop_unlocked_o)
    else $error("unlock flag high without cause");
  a_cfg_on_latch:
    assert property ($changed(div_cfg_o) |-> since_latch < 3'h5)
    else $error("divider outputs changed without a write");
  a_lock_after_count:
    assert property ($rose(lock_indicator_o) |-> $past(status_i.first_loop_locked)
      && $past(status_i.first_loop_locked, 2) && $past(status_i.first_loop_locked, 3))
    else $error("lock indicator rose too early");
  a_lock_drops_loss:
    assert property (lock_lost |-> ##[0:2] !lock_indicator_o)
    else $error("lock indicator held after loss");
  a_l2_needs_window:
    assert property ($rose(second_loop_locked_o) |-> $past(status_i.second_loop_in_window)
      && $past(status_i.second_loop_in_window, 2))
    else $error("second loop lock rose too early");
  a_hold_exit_lock:
    assert property ($fell(holdover_o) |-> $past(status_i.first_loop_locked)
      && $past(status_i.first_loop_locked, 2))
    else $error("holdover left without lock");
endmodule // pll_holdover_config_fields_chk
bind pll_holdover_config_fields pll_holdover_config_fields_chk #(.DAC_WIDTH(DAC_WIDTH)) chk_i (
  .clk_i(clk_i), .rst_i(rst_i), .serial_i(serial_i), .serial_data_o(serial_data_o),
  .status_i(status_i), .auto_dac_i(auto_dac_i), .div_cfg_o(div_cfg_o),
  .dac_value_o(dac_value_o), .dac_update_o(dac_update_o), .holdover_o(holdover_o),
  .first_loop_unlocked_o(first_loop_unlocked_o), .lock_indicator_o(lock_indicator_o),
  .second_loop_locked_o(second_loop_locked_o)
);
`default_nettype wire

/* bench/host_serial_model.sv */
`timescale 1ns/100ps
`default_nettype none
module host_serial_model (
  // clock
  input wire logic clk_i,
  // serial pins
  output var holdover_cfg_pkg::serial_in_t serial_o,
  input wire logic serial_data_i
);
  import holdover_cfg_pkg::*;
  initial serial_o = '0;
  // every pin level is held three cycles
  task automatic step(input logic c, input logic d, input logic l);
    @(posedge clk_i);
    serial_o <= '{clk: c, data: d, latch: l};
    repeat (2) @(posedge clk_i);
  endtask
  // one frame: shifts w in while capturing the readback word
  task automatic xfer(input logic [31:0] w, output logic [31:0] rd);
    for (int i = 31; i >= 0; i--)
    begin
      step(1'b0, w[i], 1'b0);
      #1;
      rd[i] = serial_data_i;
      step(1'b1, w[i], 1'b0);
    end
    step(1'b0, ~w[0], 1'b0);
    step(1'b0, w[0], 1'b1);
  endtask
endmodule // host_serial_model
`default_nettype wire

/* bench/test_pll_holdover_config_fields.sv */
`timescale 1ns/100ps
`default_nettype none
`include "holdover_cfg_defs.svh"
module test_pll_holdover_config_fields;
  import holdover_cfg_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  serial_in_t serial;
  loop_status_t st = 6'h20;
  logic [9:0] auto_dac = 10'h0aa;
  divider_cfg_t cfg;
  divider_cfg_t exp_cfg;
  logic [9:0] dac;
  logic sdo, upd, hold, unl, lock_ind, l2;
  logic [7:0] n_upd;
  logic [31:0] rd;
  int bad_count = 0;
  int n_tests = 0;
  int cycles = 0;
  pll_holdover_config_fields dut (
    .clk_i(clk_i), .rst_i(rst_i), .serial_i(serial), .serial_data_o(sdo), .status_i(st),
    .auto_dac_i(auto_dac), .div_cfg_o(cfg), .dac_value_o(dac), .dac_update_o(upd),
    .holdover_o(hold), .first_loop_unlocked_o(unl), .lock_indicator_o(lock_ind),
    .second_loop_locked_o(l2)
  );
  host_serial_model host (.clk_i(clk_i), .serial_o(serial), .serial_data_i(sdo));
  always #2 clk_i = ~clk_i;
  // detector ticks every other cycle, and the hang guard
  always @(posedge clk_i)
  begin
    st.first_pd_tick <= ~st.first_pd_tick;
    st.second_pd_tick <= ~st.second_pd_tick;
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      bad_count++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [79:0] got, input logic [79:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    host.xfer({v[31:5], a}, rd);
    cyc(2);
  endtask
  task automatic rdreg(input logic [4:0] a, output logic [31:0] v);
    wr(`ADDR_READBACK, {11'h0, a, 16'h0});
    host.xfer({11'h0, a, 11'h0, `ADDR_READBACK}, v);
    cyc(2);
  endtask
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    cyc(2);
    exp_cfg = '{6'h0, 14'd96, 14'd192, 12'd4, 18'd48, 3'h2, 1'b0, 1'b1, 2'h3, 2'h0};
    chk("cfg0", 80'(cfg), 80'(exp_cfg));
    rdreg(`ADDR_DAC_CLK, rd);
    chk("dac_clk_rb", 80'(rd & `MASK_DAC_CLK), 80'(`RST_DAC_CLK));
    rdreg(`ADDR_L2_LOCK, rd);
    chk("l2_lock_rb", 80'(rd & `MASK_L2_LOCK), 80'(`RST_L2_LOCK));
    wr(`ADDR_L2_LOCK, 32'hac0000c0);
    wr(`ADDR_DAC_CLK, 32'h010000c0);
    wr(`ADDR_L1_REF, 32'h13901800);
    wr(`ADDR_REF_FB, 32'hffffffff);
    wr(`ADDR_FB_CAL, 32'h077fffe0);
    wr(`ADDR_PRESC, 32'h057fffe0);
    rdreg(`ADDR_REF_FB, rd);
    chk("ref_fb_rb", 80'(rd & 32'hffffffe0), 80'(`MASK_REF_FB));
    exp_cfg = '{6'h39, 14'd96, 14'h3fff, 12'hfff, 18'h3ffff, 3'h5, 1'b1, 1'b0, 2'h3, 2'h2};
    chk("cfg1", 80'(cfg), 80'(exp_cfg));
    wr(`ADDR_READBACK, 32'h001f0020);
    wr(`ADDR_REF_FB, `RST_REF_FB);
    wr(5'h02, 32'hffffffe0);
    chk("locked", 80'(cfg), 80'(exp_cfg));
    wr(`ADDR_READBACK, 32'h001f0000);
    wr(`ADDR_REF_FB, `RST_REF_FB);
    exp_cfg.first_loop_fb_divider = 14'd192;
    exp_cfg.second_loop_ref_divider = 12'd4;
    chk("unlocked", 80'(cfg), 80'(exp_cfg));
    // readback level set high: a frame shifted with latch low reads blank
    wr(`ADDR_READBACK, 32'h003f0000);
    host.xfer(32'h003f001f, rd);
    cyc(2);
    chk("rblevel", 80'(rd), 80'(32'h0000_0000));
    wr(`ADDR_READBACK, 32'h001f0000);
    chk("auto", 80'(dac), 80'(auto_dac));
    // ticks every second cycle over divisor 4: one update per 8 cycles
    n_upd = 8'h00;
    repeat (80)
    begin
      @(posedge clk_i);
      n_upd = n_upd + {7'h00, upd};
    end
    chk("updates", 80'(n_upd), 80'(8'h0a));
    wr(`ADDR_DAC_MAN, 32'h555000c0);
    cyc(20);
    chk("man", 80'(dac), 80'(10'h155));
    rdreg(`ADDR_DAC_MAN, rd);
    chk("rbman", 80'(rd[31:22]), 80'(10'h155));
    wr(`ADDR_DAC_MAN, 32'h554000e0);
    cyc(20);
    rdreg(`ADDR_DAC_MAN, rd);
    chk("rbauto", 80'(rd[31:22]), 80'(auto_dac));
    chk("hold", 80'(hold), 80'(1'b1));
    st.first_loop_locked <= 1'b0;
    wr(`ADDR_DAC_MAN, 32'h554000c0);
    cyc(20);
    chk("stay", 80'({hold, lock_ind}), 80'(2'b10));
    st.first_loop_locked <= 1'b1;
    st.second_loop_in_window <= 1'b1;
    cyc(3);
    chk("early", 80'({lock_ind, l2}), 80'(2'b00));
    cyc(20);
    chk("lock", 80'({hold, lock_ind, l2}), 80'(3'b011));
    st.dac_at_high_rail <= 1'b1;
    cyc(2);
    chk("rail0", 80'(unl), 80'(1'b0));
    wr(`ADDR_DAC_TRIP, 32'hffffffff);
    chk("rail1", 80'(unl), 80'(1'b1));
    rdreg(`ADDR_DAC_TRIP, rd);
    chk("trip", 80'(rd & 32'hffffffe0), 80'(`MASK_DAC_TRIP));
    tally_and_finish();
  end
endmodule // test_pll_holdover_config_fields
`default_nettype wire
